//--- verilog/urs_pkg.sv
// Purpose: shared constants for the serial port register block
// Assumes: 3-bit register address, 8-bit data, 16 receive-clock ticks per bit
// Notes: divisor latch overlays offsets 0 and 1 while the latch-access bit is set
package urs_pkg;
	// =====================================================
	// register offsets
	localparam logic [2:0] URS_ADDR_DATA = 3'h0; // rx read / tx write / divisor low
	localparam logic [2:0] URS_ADDR_IEN = 3'h1; // irq_enable_reg / divisor high
	localparam logic [2:0] URS_ADDR_IID = 3'h2; // irq_ident_reg
	localparam logic [2:0] URS_ADDR_LFMT = 3'h3; // line_format_reg
	localparam logic [2:0] URS_ADDR_MCTL = 3'h4; // modem_ctrl_reg
	localparam logic [2:0] URS_ADDR_LST = 3'h5; // line_state_reg
	localparam logic [2:0] URS_ADDR_MST = 3'h6; // modem_state_reg
	localparam logic [2:0] URS_ADDR_SCR = 3'h7; // scratch_byte
	// =====================================================
	// field positions
	localparam int URS_LF_PAR_EN = 3;
	localparam int URS_LF_EVEN = 4;
	localparam int URS_LF_STICK = 5;
	localparam int URS_LF_BREAK = 6;
	localparam int URS_LF_DLAB = 7;
	localparam int URS_MC_DTR = 0;
	localparam int URS_MC_RTS = 1;
	localparam int URS_MC_OUT_A = 2;
	localparam int URS_MC_OUT_B = 3;
	localparam int URS_MC_LOOP = 4;
	localparam int URS_IE_RX = 0;
	localparam int URS_IE_THRE = 1;
	localparam int URS_IE_LINE = 2;
	localparam int URS_IE_MODEM = 3;
	// =====================================================
	// reset values and identification codes
	localparam logic [7:0] URS_RST_ZERO = 8'h00;
	localparam logic [7:0] URS_IID_NONE = 8'h01;
	localparam logic [7:0] URS_IID_LINE = 8'h06;
	localparam logic [7:0] URS_IID_RXD = 8'h04;
	localparam logic [7:0] URS_IID_THRE = 8'h02;
	localparam logic [7:0] URS_IID_MODEM = 8'h00;
	localparam logic [15:0] URS_RST_DIV = 16'h0001;
	// =====================================================
	// timing counts in receive-clock ticks
	localparam logic [4:0] URS_TICKS_BIT = 5'h10;
	localparam logic [4:0] URS_TICKS_HALF = 5'h08;
	localparam logic [4:0] URS_TICKS_STOP15 = 5'h18;
	localparam logic [5:0] URS_TICKS_STOP2 = 6'h20;
	localparam logic [4:0] URS_TX_WAIT = 5'h10; // lands between 8 and 24 ticks
	localparam int URS_TX_MIN = 8;
	localparam int URS_TX_MAX = 24;
endpackage : urs_pkg

//--- verilog/urs_uart.sv
// Purpose: serial port core with host register port, reset state and scratch byte
// Assumes: host strobes held at least 5 ref_clk cycles, address/data stable meanwhile
// Notes: strobe, select, serial and modem pins pass a 3-flop filter, addr and data_in do not; one receive-clock tick = divisor ref_clk cycles
// Summary of operation
// - eight-bit scratch byte reads back as written
// - reset clears interrupt enable, format, modem control
// - reset makes identification read 01 hex
// - reset clears line status bits 0-4, 7
// - reset sets line status bits 5 and 6
// - reset clears modem change bits 0-3
// - modem bits 4-7 follow inputs after reset
// - reset drives tx, user, rts, dtr high
// - rx interrupt two ref_clk cycles after stop sample
// - tx start 8-24 ticks after interrupt clear
// - modem change raises modem interrupt
// - modem status read drops modem interrupt
// - receive data read drops rx interrupt
// - holding register write drops empty interrupt
// - line status bit 5 means holding empty
// - modem bits 4-7 invert active-low inputs
`timescale 1ns/100ps
module urs_uart import urs_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// host register port
	input wire logic cs_n,
	input wire logic addr_strobe_n,
	input wire logic host_read_strobe_n,
	input wire logic host_write_strobe_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic select_echo_out,
	output logic irq_out,
	// serial and modem pins
	input wire logic rx_in,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ri_n,
	input wire logic cd_n,
	output logic tx_out,
	output logic rts_n,
	output logic dtr_n,
	output logic user_out_a_n,
	output logic user_out_b_n
);
	typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_PAR, TX_STOP} urs_tx_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} urs_rx_t;

	// parity bit for the current format, shared by both directions
	function automatic logic par_of(input logic [7:0] d, input logic [7:0] fmt);
		logic [7:0] m;
		m = 8'hFF >> (2'h3 - fmt[1:0]);
		if (fmt[URS_LF_STICK])
			par_of = ~fmt[URS_LF_EVEN];
		else
			par_of = (^(d & m)) ^ ~fmt[URS_LF_EVEN];
	endfunction : par_of

	// =====================================================
	// pin filters
	logic [8:0] raw, s1_r, s2_r, s3_r, filt_r, filt_q_r;
	assign raw = {addr_strobe_n, cd_n, ri_n, dsr_n, cts_n, rx_in, host_read_strobe_n, host_write_strobe_n, cs_n};
	// a bit changes only once the second and third stages agree
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_r <= 9'h1FF;
			s2_r <= 9'h1FF;
			s3_r <= 9'h1FF;
			filt_r <= 9'h1FF;
			filt_q_r <= 9'h1FF;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
			filt_q_r <= filt_r;
		end
	end
	logic sel, rd_go, rd_end, wr_go;
	assign sel = ~filt_r[0];
	assign rd_go = sel & filt_q_r[2] & ~filt_r[2];
	assign rd_end = ~filt_q_r[2] & filt_r[2];
	assign wr_go = sel & filt_q_r[1] & ~filt_r[1];

	// =====================================================
	// host registers
	logic [3:0] ien_r;
	logic [7:0] lfmt_r, scr_r, thr_r;
	logic [4:0] mctl_r;
	logic [15:0] div_r;
	logic thr_full_r, tx_load;
	logic [2:0] a;
	logic dlab, loop;
	assign a = addr;
	assign dlab = lfmt_r[URS_LF_DLAB];
	assign loop = mctl_r[URS_MC_LOOP];
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ien_r <= URS_RST_ZERO[3:0];
			lfmt_r <= URS_RST_ZERO;
			mctl_r <= URS_RST_ZERO[4:0];
			scr_r <= URS_RST_ZERO;
			div_r <= URS_RST_DIV;
			thr_r <= URS_RST_ZERO;
		end else if (wr_go) begin
			if (a == URS_ADDR_DATA && dlab)
				div_r[7:0] <= data_in;
			else if (a == URS_ADDR_DATA)
				thr_r <= data_in;
			else if (a == URS_ADDR_IEN && dlab)
				div_r[15:8] <= data_in;
			else if (a == URS_ADDR_IEN)
				ien_r <= data_in[3:0];
			else if (a == URS_ADDR_LFMT)
				lfmt_r <= data_in;
			else if (a == URS_ADDR_MCTL)
				mctl_r <= data_in[4:0];
			else if (a == URS_ADDR_SCR)
				scr_r <= data_in; // no side effect anywhere
		end
	end
	logic thr_wr;
	assign thr_wr = wr_go && a == URS_ADDR_DATA && !dlab;

	// =====================================================
	// receive-clock tick from the divisor
	logic [15:0] bcnt_r;
	logic tick;
	assign tick = (bcnt_r == 16'h0001) || (div_r == 16'h0001); // a zero divisor is unsupported
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			bcnt_r <= URS_RST_DIV;
		else if (tick)
			bcnt_r <= div_r;
		else
			bcnt_r <= bcnt_r - 16'h0001;
	end

	// =====================================================
	// transmitter
	urs_tx_t tx_st_r;
	logic [7:0] tsr_r;
	logic [5:0] tx_cnt_r;
	logic [2:0] tx_bit_r;
	logic tx_line, tx_int;
	logic tx_par_r;
	assign tx_load = (tx_st_r == TX_IDLE) && thr_full_r;
	// holding register empties as soon as the shifter takes the byte
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			thr_full_r <= 1'b0; // reads as empty after reset
		else if (thr_wr)
			thr_full_r <= 1'b1;
		else if (tx_load)
			thr_full_r <= 1'b0;
	end
	always_comb begin
		case (tx_st_r)
			TX_START: tx_line = 1'b0;
			TX_DATA: tx_line = tsr_r[0];
			TX_PAR: tx_line = tx_par_r;
			default: tx_line = 1'b1;
		endcase
	end
	assign tx_int = lfmt_r[URS_LF_BREAK] ? 1'b0 : tx_line;
	// bit timer counts ticks; wait state spaces the start bit after the load
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_st_r <= TX_IDLE;
			tsr_r <= URS_RST_ZERO;
			tx_cnt_r <= 6'h00;
			tx_bit_r <= 3'h0;
			tx_par_r <= 1'b0;
		end else begin
			case (tx_st_r)
				TX_IDLE: if (tx_load) begin
					tsr_r <= thr_r;
					// parity fixed at load: the holding register may refill mid-frame
					tx_par_r <= par_of(thr_r, lfmt_r);
					tx_cnt_r <= 6'h00;
					tx_st_r <= TX_WAIT;
				end
				default: if (tick) begin
					tx_cnt_r <= tx_cnt_r + 6'h01;
					if (tx_st_r == TX_WAIT && tx_cnt_r == {1'b0, URS_TX_WAIT - 5'h01}) begin
						tx_st_r <= TX_START;
						tx_cnt_r <= 6'h00;
					end else if (tx_st_r == TX_START && tx_cnt_r == {1'b0, URS_TICKS_BIT - 5'h01}) begin
						tx_st_r <= TX_DATA;
						tx_cnt_r <= 6'h00;
						tx_bit_r <= 3'h0;
					end else if (tx_st_r == TX_DATA && tx_cnt_r == {1'b0, URS_TICKS_BIT - 5'h01}) begin
						tx_cnt_r <= 6'h00;
						tx_bit_r <= tx_bit_r + 3'h1;
						tsr_r <= {1'b0, tsr_r[7:1]};
						if (tx_bit_r == {1'b1, lfmt_r[1:0]})
							tx_st_r <= lfmt_r[URS_LF_PAR_EN] ? TX_PAR : TX_STOP;
					end else if (tx_st_r == TX_PAR && tx_cnt_r == {1'b0, URS_TICKS_BIT - 5'h01}) begin
						tx_cnt_r <= 6'h00;
						tx_st_r <= TX_STOP;
					end else if (tx_st_r == TX_STOP && (tx_cnt_r == {1'b0, URS_TICKS_BIT - 5'h01} && !lfmt_r[2]
						|| tx_cnt_r == {1'b0, URS_TICKS_STOP15 - 5'h01} && lfmt_r[1:0] == 2'h0 && lfmt_r[2]
						|| tx_cnt_r == URS_TICKS_STOP2 - 6'h01)) begin
						tx_st_r <= TX_IDLE;
					end
				end
			endcase
		end
	end

	// =====================================================
	// receiver; loopback takes the transmitter's line
	urs_rx_t rx_st_r;
	logic [7:0] rsh_r, rbr_r;
	logic [4:0] rx_cnt_r;
	logic [2:0] rx_bit_r;
	logic rx_line, rx_perr_r, rx_stop_ev;
	logic dr_r, oe_r, pe_r, fe_r, bi_r;
	assign rx_line = loop ? tx_int : filt_r[3];
	assign rx_stop_ev = tick && rx_st_r == RX_STOP && rx_cnt_r == URS_TICKS_BIT - 5'h01;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_st_r <= RX_IDLE;
			rsh_r <= URS_RST_ZERO;
			rx_cnt_r <= 5'h00;
			rx_bit_r <= 3'h0;
			rx_perr_r <= 1'b0;
		end else if (tick) begin
			rx_cnt_r <= rx_cnt_r + 5'h01;
			case (rx_st_r)
				RX_IDLE: begin
					rx_cnt_r <= 5'h00;
					if (!rx_line)
						rx_st_r <= RX_START;
				end
				RX_START: if (rx_cnt_r == URS_TICKS_HALF - 5'h01) begin
					// re-align to mid-bit; a glitch returns to idle
					rx_cnt_r <= 5'h00;
					rx_bit_r <= 3'h0;
					rsh_r <= URS_RST_ZERO;
					rx_st_r <= rx_line ? RX_IDLE : RX_DATA;
				end
				RX_DATA: if (rx_cnt_r == URS_TICKS_BIT - 5'h01) begin
					rx_cnt_r <= 5'h00;
					rx_bit_r <= rx_bit_r + 3'h1;
					rsh_r <= {rx_line, rsh_r[7:1]};
					if (rx_bit_r == {1'b1, lfmt_r[1:0]})
						rx_st_r <= lfmt_r[URS_LF_PAR_EN] ? RX_PAR : RX_STOP;
				end
				RX_PAR: if (rx_cnt_r == URS_TICKS_BIT - 5'h01) begin
					rx_cnt_r <= 5'h00;
					rsh_r <= rsh_r >> (2'h3 - lfmt_r[1:0]);
					rx_perr_r <= rx_line ^ par_of(rsh_r >> (2'h3 - lfmt_r[1:0]), lfmt_r);
					rx_st_r <= RX_STOP;
				end
				default: if (rx_cnt_r == URS_TICKS_BIT - 5'h01) begin
					rx_perr_r <= 1'b0;
					rx_st_r <= RX_IDLE;
				end
			endcase
		end
	end
	logic [7:0] rx_word;
	assign rx_word = lfmt_r[URS_LF_PAR_EN] ? rsh_r : rsh_r >> (2'h3 - lfmt_r[1:0]);

	// =====================================================
	// status, read data and read side effects
	logic [3:0] lvl, lvl_q_r, dlt_r, dlt_set;
	logic lvl_vld_r, thre_ip_r;
	logic [3:0] arm_r;
	logic [7:0] lst, mst, iid, rd_val;
	assign lst = {1'b0, ~thr_full_r & (tx_st_r == TX_IDLE), ~thr_full_r, bi_r, fe_r, pe_r, oe_r, dr_r};
	// loopback maps cd/ri/dsr/cts onto out_b/out_a/dtr/rts
	assign lvl = loop ? {mctl_r[URS_MC_OUT_B], mctl_r[URS_MC_OUT_A], mctl_r[URS_MC_DTR], mctl_r[URS_MC_RTS]}
		: ~filt_r[7:4];
	assign mst = {lvl, dlt_r};
	assign dlt_set = lvl_vld_r ? {lvl[3] ^ lvl_q_r[3], lvl_q_r[2] & ~lvl[2], lvl[1:0] ^ lvl_q_r[1:0]} : 4'h0;
	// fixed priority: line errors, data, holding empty, modem
	always_comb begin
		if (ien_r[URS_IE_LINE] && |lst[4:1])
			iid = URS_IID_LINE;
		else if (ien_r[URS_IE_RX] && dr_r)
			iid = URS_IID_RXD;
		else if (ien_r[URS_IE_THRE] && thre_ip_r)
			iid = URS_IID_THRE;
		else if (ien_r[URS_IE_MODEM] && |dlt_r)
			iid = URS_IID_MODEM;
		else
			iid = URS_IID_NONE;
	end
	always_comb begin
		if (a == URS_ADDR_DATA && dlab)
			rd_val = div_r[7:0];
		else if (a == URS_ADDR_DATA)
			rd_val = rbr_r;
		else if (a == URS_ADDR_IEN && dlab)
			rd_val = div_r[15:8];
		else if (a == URS_ADDR_IEN)
			rd_val = {4'h0, ien_r};
		else if (a == URS_ADDR_IID)
			rd_val = iid;
		else if (a == URS_ADDR_LFMT)
			rd_val = lfmt_r;
		else if (a == URS_ADDR_MCTL)
			rd_val = {3'h0, mctl_r};
		else if (a == URS_ADDR_LST)
			rd_val = lst;
		else if (a == URS_ADDR_MST)
			rd_val = mst;
		else
			rd_val = scr_r;
	end
	logic rd_rbr, rd_lst, rd_mst, rd_iid;
	assign rd_rbr = rd_go && a == URS_ADDR_DATA && !dlab;
	assign rd_lst = rd_go && a == URS_ADDR_LST;
	assign rd_mst = rd_go && a == URS_ADDR_MST;
	assign rd_iid = rd_go && a == URS_ADDR_IID;
	// receive flags: a stop-bit event wins over a status read; a data read in that cycle clears ready only if ready was already set
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			dr_r <= 1'b0;
			{oe_r, pe_r, fe_r, bi_r} <= 4'h0;
			rbr_r <= URS_RST_ZERO;
		end else begin
			if (rx_stop_ev && !dr_r) begin
				rbr_r <= rx_word;
				dr_r <= 1'b1;
			end else if (rd_rbr)
				dr_r <= 1'b0;
			if (rx_stop_ev)
				{oe_r, pe_r, fe_r, bi_r} <= {dr_r | oe_r, rx_perr_r | pe_r, ~rx_line | fe_r,
					(rsh_r == 8'h00 && !rx_line) | bi_r};
			else if (rd_lst)
				{oe_r, pe_r, fe_r, bi_r} <= 4'h0;
		end
	end
	// modem change bits and holding-empty pending flag
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			dlt_r <= 4'h0;
			lvl_q_r <= 4'h0;
			lvl_vld_r <= 1'b0;
			arm_r <= 4'h0;
			thre_ip_r <= 1'b0;
		end else begin
			lvl_q_r <= lvl;
			// filters restart at idle; arm only once they have caught up with the pins
			// so active modem inputs at release raise no change (a real change then is lost)
			arm_r <= {arm_r[2:0], 1'b1};
			lvl_vld_r <= arm_r[3];
			dlt_r <= (rd_mst ? 4'h0 : dlt_r) | dlt_set;
			if (tx_load)
				thre_ip_r <= 1'b1;
			else if (thr_wr || (rd_iid && iid == URS_IID_THRE))
				thre_ip_r <= 1'b0;
		end
	end

	// =====================================================
	// registered outputs
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_out <= 1'b1;
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
			user_out_a_n <= 1'b1;
			user_out_b_n <= 1'b1;
			irq_out <= 1'b0;
			select_echo_out <= 1'b0;
			data_out <= URS_RST_ZERO;
			data_oe <= 1'b0;
		end else begin
			// loopback parks every line output at idle
			tx_out <= loop | tx_int;
			rts_n <= loop | ~mctl_r[URS_MC_RTS];
			dtr_n <= loop | ~mctl_r[URS_MC_DTR];
			user_out_a_n <= loop | ~mctl_r[URS_MC_OUT_A];
			user_out_b_n <= loop | ~mctl_r[URS_MC_OUT_B];
			irq_out <= ~iid[0];
			select_echo_out <= sel;
			if (rd_go) begin
				data_out <= rd_val;
				data_oe <= 1'b1;
			end else if (rd_end)
				data_oe <= 1'b0;
		end
	end

	// =====================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	logic [5:0] tw_r;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			tw_r <= 6'h00;
		else if (tx_load)
			tw_r <= 6'h00;
		else if (tick && tx_st_r == TX_WAIT)
			tw_r <= tw_r + 6'h01;
	end
	sequence s_scr_write;
		wr_go && a == URS_ADDR_SCR;
	endsequence
	a_scratch_hold: assert property (s_scr_write |=> scr_r == $past(data_in)) else $error("scratch lost");
	a_ctrl_reset: assert property ($rose(arst_n) |-> ien_r == 4'h0 && lfmt_r == 8'h00 && mctl_r == 5'h00)
		else $error("ctrl reset");
	a_iid_idle: assert property (ien_r == 4'h0 |-> iid == URS_IID_NONE) else $error("iid not idle");
	a_lst_reset: assert property ($rose(arst_n) |-> lst == 8'h60) else $error("lst reset");
	a_dlt_reset: assert property ($rose(arst_n) |-> dlt_r == 4'h0) else $error("dlt reset");
	a_msr_follow: assert property (!loop |-> mst[7:4] == ~filt_r[7:4]) else $error("msr level");
	a_pins_idle: assert property ($past(loop) |-> tx_out && rts_n && dtr_n) else $error("pins not idle");
	a_pins_reset: assert property ($rose(arst_n) |-> tx_out && rts_n && dtr_n && user_out_a_n && user_out_b_n)
		else $error("pins reset");
	a_rx_irq: assert property (rx_stop_ev && !dr_r && ien_r[0] && ien_r[2] == 1'b0 |=> ##1 irq_out) else $error("rx irq");
	a_tx_space: assert property (tx_st_r == TX_WAIT ##1 tx_st_r == TX_START |-> tw_r >= URS_TX_MIN && tw_r <= URS_TX_MAX)
		else $error("tx spacing");
	a_modem_irq: assert property (|dlt_set && ien_r == 4'h8 |=> ##1 irq_out) else $error("modem irq");
	a_msr_clear: assert property (rd_mst && !(|dlt_set) |=> dlt_r == 4'h0) else $error("msr clear");
	a_thr_clear: assert property (thr_wr && !tx_load |=> !thre_ip_r) else $error("thre clear");
	a_thre_bit: assert property (thr_wr |=> !lst[5]) else $error("thre bit");
endmodule : urs_uart

//--- tb/urs_peer.sv
// Purpose: far-side serial peer and modem model for the serial port block
// Assumes: divisor 1, so one bit lasts 16 ref_clk cycles; 8 data bits, no parity
// Notes: lines idle high; modem inputs move only when the bench asks
`timescale 1ns/100ps
module urs_peer (
	// clock
	input wire logic ref_clk,
	// serial lines
	output logic rx_in,
	input wire logic tx_out,
	// modem lines, active low
	output logic cts_n,
	output logic dsr_n,
	output logic ri_n,
	output logic cd_n
);
	// ==============================
	// line state
	localparam int BIT_CYC = 16;
	// mark level and no modem signal asserted until told otherwise
	initial begin
		rx_in = 1'b1;
		{cd_n, ri_n, dsr_n, cts_n} = 4'hF;
	end
	// ==============================
	// tasks
	// pin levels given as {cd, ri, dsr, cts}
	task automatic set_modem(input logic [3:0] lv);
		@(posedge ref_clk);
		{cd_n, ri_n, dsr_n, cts_n} <= lv;
	endtask : set_modem
	// start, data lsb first, one stop; line left at mark
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk);
			rx_in <= frame[i];
			repeat (BIT_CYC - 1) @(posedge ref_clk);
		end
	endtask : send_byte
	// counts cycles until a start bit, then samples each bit mid-cell
	task automatic recv_byte(output logic [7:0] b, output logic ok, output int n);
		b = 8'h00;
		ok = 1'b0;
		for (n = 0; n < 2000 && tx_out !== 1'b0; n++) begin
			@(posedge ref_clk);
			#1;
		end
		if (tx_out === 1'b0) begin
			repeat (BIT_CYC / 2) @(posedge ref_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge ref_clk);
				#1;
				b[i] = tx_out;
			end
			repeat (BIT_CYC) @(posedge ref_clk);
			#1;
			ok = tx_out;
		end
	endtask : recv_byte
endmodule : urs_peer

//--- tb/tb_top.sv
// Purpose: self-checking bench for the serial port register block
// Assumes: divisor stays at its reset value of one, 8 data bits, 1 stop
// Notes: strobes held 6 cycles with 6-cycle gaps, well past the 3-flop filters
`timescale 1ns/100ps
module tb_top import urs_pkg::*; ();
	// ==============================
	// pins and bookkeeping
	logic ref_clk, arst_n, cs_n, host_read_strobe_n, host_write_strobe_n;
	logic [2:0] addr;
	logic [7:0] data_in, data_out, rd_b, b1, b2;
	logic data_oe, select_echo_out, irq_out, rx_in, tx_out;
	logic cts_n, dsr_n, ri_n, cd_n, rts_n, dtr_n, user_out_a_n, user_out_b_n;
	logic ok1, ok2;
	int n1, n2;
	int failures = 0;
	int comparisons = 0;
	logic [7:0] pat [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
	// ==============================
	// design and far side; address strobe unused by the design
	urs_uart dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n), .addr_strobe_n(1'b0),
		.host_read_strobe_n(host_read_strobe_n), .host_write_strobe_n(host_write_strobe_n),
		.addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.select_echo_out(select_echo_out), .irq_out(irq_out), .rx_in(rx_in), .cts_n(cts_n),
		.dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .tx_out(tx_out), .rts_n(rts_n), .dtr_n(dtr_n),
		.user_out_a_n(user_out_a_n), .user_out_b_n(user_out_b_n));
	urs_peer peer_u (.ref_clk(ref_clk), .rx_in(rx_in), .tx_out(tx_out), .cts_n(cts_n),
		.dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n));
	// 50 MHz
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ==============================
	// compare and verdict
	task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check_byte
	task automatic check_bit(input string name, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask : check_bit
	task automatic print_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict
	// ==============================
	// host access; select leads and trails the strobe by a cycle
	task automatic host_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		cs_n <= 1'b0;
		addr <= a;
		data_in <= d;
		@(posedge ref_clk);
		host_write_strobe_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		host_write_strobe_n <= 1'b1;
		@(posedge ref_clk);
		cs_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
	endtask : host_write
	task automatic host_read(input logic [2:0] a, output logic [7:0] d);
		int n;
		@(posedge ref_clk);
		cs_n <= 1'b0;
		addr <= a;
		@(posedge ref_clk);
		host_read_strobe_n <= 1'b0;
		for (n = 0; n < 20 && data_oe !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		d = data_out;
		check_bit("select_echo_out", 1'b1, select_echo_out);
		if (n == 20) begin
			check_bit("data_oe", 1'b1, data_oe);
			print_verdict();
		end
		@(posedge ref_clk);
		host_read_strobe_n <= 1'b1;
		@(posedge ref_clk);
		cs_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
	endtask : host_read
	// bounded wait on the interrupt pin; a miss ends the run
	task automatic expect_irq(input logic exp, input int lim);
		int n;
		for (n = 0; n < lim && irq_out !== exp; n++) begin
			@(posedge ref_clk);
			#1;
		end
		check_bit("irq_out", exp, irq_out);
		if (irq_out !== exp) begin
			print_verdict();
		end
	endtask : expect_irq
	// pins checked while reset is held, registers read after release
	task automatic do_reset(input logic [7:0] exp_mst);
		logic [2:0] ra [6];
		logic [7:0] rv [6];
		ra = '{URS_ADDR_IEN, URS_ADDR_LFMT, URS_ADDR_MCTL, URS_ADDR_IID, URS_ADDR_LST, URS_ADDR_MST};
		rv = '{8'h00, 8'h00, 8'h00, URS_IID_NONE, 8'h60, exp_mst};
		@(posedge ref_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		check_byte("reset pins", 8'h1F, {3'h0, tx_out, rts_n, dtr_n, user_out_a_n, user_out_b_n});
		check_byte("reset irq oe echo", 8'h00, {5'h0, irq_out, data_oe, select_echo_out});
		@(posedge ref_clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			host_read(ra[i], rd_b);
			check_byte($sformatf("reset reg %0d", ra[i]), rv[i], rd_b);
		end
	endtask : do_reset
	// ==============================
	// hang guard
	initial begin
		repeat (60000) @(posedge ref_clk);
		failures++;
		$display("mismatch watchdog expected done seen running");
		print_verdict();
	end
	// ==============================
	// main sequence; divisor left at one, never zero
	initial begin
		arst_n = 1'b0;
		cs_n = 1'b1;
		host_read_strobe_n = 1'b1;
		host_write_strobe_n = 1'b1;
		addr = 3'h0;
		data_in = 8'h00;
		do_reset(8'h00);
		// scratch patterns, then status untouched
		for (int i = 0; i < 4; i++) begin
			host_write(URS_ADDR_SCR, pat[i]);
			host_read(URS_ADDR_SCR, rd_b);
			check_byte("scratch_byte", pat[i], rd_b);
		end
		host_read(URS_ADDR_LST, rd_b);
		check_byte("line_state_reg", 8'h60, rd_b);
		// receive with data interrupt enabled
		host_write(URS_ADDR_LFMT, 8'h03);
		host_write(URS_ADDR_IEN, 8'h01);
		peer_u.send_byte(8'hA5);
		expect_irq(1'b1, 4);
		host_read(URS_ADDR_IID, rd_b);
		check_byte("irq_ident_reg", URS_IID_RXD, rd_b);
		host_read(URS_ADDR_DATA, rd_b);
		check_byte("rx data", 8'hA5, rd_b);
		expect_irq(1'b0, 4);
		// back-to-back transmit: second byte written while the first waits in the shifter before its start bit
		host_write(URS_ADDR_IEN, 8'h02);
		fork
			begin
				host_write(URS_ADDR_DATA, 8'h3C);
				expect_irq(1'b1, 8);
				host_write(URS_ADDR_DATA, 8'h81);
				expect_irq(1'b0, 4);
				host_read(URS_ADDR_LST, rd_b);
				check_byte("line_state_reg busy", 8'h00, rd_b);
			end
			begin
				peer_u.recv_byte(b1, ok1, n1);
				peer_u.recv_byte(b2, ok2, n2);
			end
		join
		check_bit("tx start window", 1'b1, n1 >= URS_TX_MIN + 3 && n1 <= URS_TX_MAX + 9);
		check_byte("tx byte 1", 8'h3C, b1);
		check_byte("tx byte 2", 8'h81, b2);
		check_byte("tx stop bits", 8'h03, {6'h0, ok1, ok2});
		expect_irq(1'b1, 40);
		host_read(URS_ADDR_IID, rd_b);
		check_byte("irq_ident_reg", URS_IID_THRE, rd_b);
		expect_irq(1'b0, 4);
		host_read(URS_ADDR_LST, rd_b);
		check_byte("line_state_reg idle", 8'h60, rd_b);
		// modem changes; ring falling must not flag a change
		host_write(URS_ADDR_IEN, 8'h08);
		peer_u.set_modem(4'hE);
		expect_irq(1'b1, 10);
		host_read(URS_ADDR_IID, rd_b);
		check_byte("irq_ident_reg", URS_IID_MODEM, rd_b);
		host_read(URS_ADDR_MST, rd_b);
		check_byte("modem_state_reg", 8'h11, rd_b);
		expect_irq(1'b0, 4);
		peer_u.set_modem(4'h0);
		expect_irq(1'b1, 10);
		host_read(URS_ADDR_MST, rd_b);
		check_byte("modem_state_reg", 8'hFA, rd_b);
		expect_irq(1'b0, 4);
		// loopback parks line outputs high; modem levels follow control bits
		host_write(URS_ADDR_MCTL, 8'h13);
		check_byte("loop pins", 8'h1F, {3'h0, tx_out, rts_n, dtr_n, user_out_a_n, user_out_b_n});
		host_read(URS_ADDR_MST, rd_b);
		check_byte("modem_state_reg loop", 8'h3C, rd_b);
		// outputs driven low, then a second reset in mid-run
		host_write(URS_ADDR_MCTL, 8'h0F);
		check_byte("modem outputs", 8'h00, {4'h0, rts_n, dtr_n, user_out_a_n, user_out_b_n});
		do_reset(8'hF0);
		print_verdict();
	end
endmodule : tb_top
